/* File: hw/tppm_pkg.sv */
// Constants and types for the three-phase pwm modulator
package tppm_pkg;
  localparam logic [2:0] ADDR_PH1 = 3'h0;
  localparam logic [2:0] ADDR_PH2 = 3'h1;
  localparam logic [2:0] ADDR_PH3 = 3'h2;
  localparam logic [2:0] ADDR_DEAD = 3'h3;
  localparam logic [2:0] ADDR_DIV = 3'h4;
  localparam int NCH = 3;
  localparam int DLY_STAGES = 15;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [3:0] SET_RST = 4'h0;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [5:0] DIV_RST = 6'h00;
  localparam logic [3:0] DEAD_RST = 4'h0;
  localparam logic [3:0] DCLK_RST = 4'h0;
  localparam logic [3:0] DCLK_EVEN_N = 4'h4;
  localparam logic [3:0] DCLK_ODD_N = 4'h6;
  // Counter division ratio per divider setting
  typedef logic [5:0] tppm_ratio_t;
  localparam tppm_ratio_t RATIO [8] = '{6'h04, 6'h06, 6'h08, 6'h0c,
                                        6'h10, 6'h18, 6'h20, 6'h30};
  typedef struct packed {
    logic drive_n;
    logic complement;
  } tppm_pair_t;
endpackage

/* File: hw/tppm_top.sv */
// Three-phase pwm modulator with host bus, prescaler and dead time
`timescale 1ns/10ps
`default_nettype none
module tppm_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] host_bus,
  input wire logic addr_latch,
  input wire logic write_strobe,
  input wire logic chip_select,
  input wire logic trigger,
  input wire logic inhibit,
  input wire logic set_status,
  input wire logic clear_status,
  input wire logic chip_reset_in,
  output logic crystal_out,
  output logic status_out,
  output logic phase_one_drive_out,
  output logic phase_one_complement_out,
  output logic phase_two_drive_out,
  output logic phase_two_complement_out,
  output logic phase_three_drive_out,
  output logic phase_three_complement_out
);
  logic ale_q_r, wr_q_r;
  logic [2:0] addr_r;
  logic [7:0] phase_r [tppm_pkg::NCH];
  logic [3:0] dead_r, div_r;
  logic [5:0] pre_cnt_r;
  logic cnt_tick;
  logic [3:0] dclk_cnt_r;
  logic dclk_tick;
  logic [7:0] cnt_r [tppm_pkg::NCH];
  logic [tppm_pkg::NCH-1:0] raw_n;
  logic [tppm_pkg::DLY_STAGES-1:0] sr_r [tppm_pkg::NCH];
  logic [tppm_pkg::NCH-1:0] del_n;
  logic status_r;
  logic block;
  tppm_pkg::tppm_pair_t pair_r [tppm_pkg::NCH];
  tppm_pkg::tppm_pair_t pair_nxt [tppm_pkg::NCH];

  // Crystal passed straight back to the host
  assign crystal_out = clk;

  // Strobe edge detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ale_q_r <= 1'b0;
      // Idle level of the write strobe, so no false edge after reset
      wr_q_r <= 1'b1;
    end else if (clk_en) begin
      ale_q_r <= addr_latch;
      wr_q_r <= write_strobe;
    end
  end

  // Address captured on falling edge of the latch strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_r <= tppm_pkg::ADDR_PH1;
    end else if (clk_en && ale_q_r && !addr_latch) begin
      addr_r <= host_bus[2:0];
    end
  end

  // Register writes on rising edge of write strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < tppm_pkg::NCH; i++) begin
        phase_r[i] <= tppm_pkg::PHASE_RST;
      end
      dead_r <= tppm_pkg::SET_RST;
      div_r <= tppm_pkg::SET_RST;
    end else if (clk_en && !wr_q_r && write_strobe
                 && chip_select) begin
      case (addr_r)
        tppm_pkg::ADDR_PH1: begin
          phase_r[0] <= host_bus;
        end
        tppm_pkg::ADDR_PH2: begin
          phase_r[1] <= host_bus;
        end
        tppm_pkg::ADDR_PH3: begin
          phase_r[2] <= host_bus;
        end
        tppm_pkg::ADDR_DEAD: begin
          dead_r <= host_bus[3:0];
        end
        tppm_pkg::ADDR_DIV: begin
          div_r <= host_bus[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Counter prescaler
  // Compare by at-least, so a smaller new ratio does not wrap the count
  assign cnt_tick = (pre_cnt_r >=
                     tppm_pkg::RATIO[div_r[2:0]] - 6'h01);
  always_ff @(posedge clk) begin
    if (!resetn || chip_reset_in) begin
      pre_cnt_r <= tppm_pkg::DIV_RST;
    end else if (clk_en) begin
      pre_cnt_r <= cnt_tick ? tppm_pkg::DIV_RST : pre_cnt_r + 6'h01;
    end
  end

  // Delay clock: by 4 on even settings, by 6 on odd
  assign dclk_tick = (dclk_cnt_r >= (div_r[0] ? tppm_pkg::DCLK_ODD_N
                                               : tppm_pkg::DCLK_EVEN_N)
                      - 4'h1);
  always_ff @(posedge clk) begin
    if (!resetn || chip_reset_in) begin
      dclk_cnt_r <= tppm_pkg::DCLK_RST;
    end else if (clk_en) begin
      dclk_cnt_r <= dclk_tick ? tppm_pkg::DCLK_RST : dclk_cnt_r + 4'h1;
    end
  end

  // Channel counters
  always_ff @(posedge clk) begin
    if (!resetn || chip_reset_in) begin
      for (int i = 0; i < tppm_pkg::NCH; i++) begin
        cnt_r[i] <= tppm_pkg::ZERO8;
      end
    end else if (clk_en) begin
      for (int i = 0; i < tppm_pkg::NCH; i++) begin
        if (trigger) begin
          cnt_r[i] <= phase_r[i];
        end else if (cnt_tick && cnt_r[i] != tppm_pkg::ZERO8) begin
          cnt_r[i] <= cnt_r[i] - 8'h01;
        end
      end
    end
  end

  // Zero detector: output low while counter nonzero
  always_comb begin
    for (int i = 0; i < tppm_pkg::NCH; i++) begin
      raw_n[i] = ~|cnt_r[i];
    end
  end

  // Dead-time shift register on the delay clock
  always_ff @(posedge clk) begin
    if (!resetn || chip_reset_in) begin
      for (int i = 0; i < tppm_pkg::NCH; i++) begin
        sr_r[i] <= '1;
      end
    end else if (clk_en && dclk_tick) begin
      for (int i = 0; i < tppm_pkg::NCH; i++) begin
        sr_r[i] <= {sr_r[i][tppm_pkg::DLY_STAGES-2:0], raw_n[i]};
      end
    end
  end

  // Delayed drive: falls only after delay, rises at once
  always_comb begin
    for (int i = 0; i < tppm_pkg::NCH; i++) begin
      if (dead_r == tppm_pkg::DEAD_RST) begin
        del_n[i] = raw_n[i];
      end else begin
        del_n[i] = raw_n[i] | sr_r[i][dead_r - 4'h1];
      end
    end
  end

  // Status flip-flop, set dominates clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_r <= 1'b0;
    end else if (clk_en) begin
      if (set_status) begin
        status_r <= 1'b1;
      end else if (clear_status) begin
        status_r <= 1'b0;
      end
    end
  end
  assign status_out = status_r;

  assign block = inhibit | status_r | chip_reset_in;

  // Output pairs; complement is high while drive is active
  always_comb begin
    for (int i = 0; i < tppm_pkg::NCH; i++) begin
      if (block) begin
        pair_nxt[i] = '{drive_n: 1'b1, complement: 1'b1};
      end else if (dead_r == tppm_pkg::DEAD_RST) begin
        pair_nxt[i] = '{drive_n: raw_n[i], complement: ~raw_n[i]};
      end else begin
        // Each side's falling edge delayed relative to the other
        pair_nxt[i] = '{drive_n: del_n[i],
                        complement: ~raw_n[i] |
                          ~sr_r[i][dead_r - 4'h1]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < tppm_pkg::NCH; i++) begin
        pair_r[i] <= '{drive_n: 1'b1, complement: 1'b1};
      end
    end else if (clk_en) begin
      for (int i = 0; i < tppm_pkg::NCH; i++) begin
        pair_r[i] <= pair_nxt[i];
      end
    end
  end

  assign phase_one_drive_out = pair_r[0].drive_n;
  assign phase_one_complement_out = pair_r[0].complement;
  assign phase_two_drive_out = pair_r[1].drive_n;
  assign phase_two_complement_out = pair_r[1].complement;
  assign phase_three_drive_out = pair_r[2].drive_n;
  assign phase_three_complement_out = pair_r[2].complement;
endmodule
`default_nettype wire

/* File: bench/tppm_checker.sv */
// Port assertions for the three-phase pwm modulator
`timescale 1ns/10ps
`default_nettype none
module tppm_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inhibit,
  input wire logic set_status,
  input wire logic clear_status,
  input wire logic chip_reset_in,
  input wire logic crystal_out,
  input wire logic status_out,
  input wire logic phase_one_drive_out,
  input wire logic phase_one_complement_out,
  input wire logic phase_two_drive_out,
  input wire logic phase_two_complement_out,
  input wire logic phase_three_drive_out,
  input wire logic phase_three_complement_out
);
  logic [5:0] o;
  assign o = {phase_one_drive_out, phase_one_complement_out,
    phase_two_drive_out, phase_two_complement_out,
    phase_three_drive_out, phase_three_complement_out};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_clk_out_high: assert property (@(negedge clk) crystal_out)
    else $error("clock output low in high phase");
  a_inhibit_force: assert property (inhibit |=> &o)
    else $error("outputs not high under inhibit");
  a_reset_force: assert property (chip_reset_in |=> &o)
    else $error("outputs not high under chip reset");
  a_status_set: assert property (set_status |=> status_out)
    else $error("status not set");
  a_status_clr: assert property (clear_status && !set_status
    |=> !status_out)
    else $error("status not cleared");
  a_status_keep: assert property (!set_status && !clear_status
    |=> $stable(status_out))
    else $error("status changed without cause");
  a_status_block: assert property (status_out && $past(status_out)
    |-> &o)
    else $error("outputs not held high while status set");
  a_pair_excl: assert property ((o[5] | o[4]) && (o[3] | o[2])
    && (o[1] | o[0]))
    else $error("both outputs of a phase active");
endmodule
bind tppm_top tppm_checker chk_u (.clk(clk), .resetn(resetn),
  .inhibit(inhibit), .set_status(set_status),
  .clear_status(clear_status), .chip_reset_in(chip_reset_in),
  .crystal_out(crystal_out), .status_out(status_out),
  .phase_one_drive_out(phase_one_drive_out),
  .phase_one_complement_out(phase_one_complement_out),
  .phase_two_drive_out(phase_two_drive_out),
  .phase_two_complement_out(phase_two_complement_out),
  .phase_three_drive_out(phase_three_drive_out),
  .phase_three_complement_out(phase_three_complement_out));
`default_nettype wire

/* File: bench/tppm_host.sv */
// Host controller model driving the multiplexed bus and trigger
`timescale 1ns/10ps
`default_nettype none
module tppm_host (
  input wire logic clk,
  output logic [7:0] host_bus,
  output logic addr_latch,
  output logic write_strobe,
  output logic chip_select,
  output logic trigger
);
  initial begin
    host_bus = 8'h00;
    addr_latch = 1'b0;
    write_strobe = 1'b1;
    chip_select = 1'b0;
    trigger = 1'b0;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d,
    input logic cs);
    @(negedge clk);
    host_bus = {5'h00, a};
    addr_latch = 1'b1;
    @(negedge clk);
    addr_latch = 1'b0;
    @(negedge clk);
    host_bus = d;
    write_strobe = 1'b0;
    chip_select = cs;
    @(negedge clk);
    write_strobe = 1'b1;
    @(negedge clk);
    // Released bus shows no stale data
    host_bus = ~d;
    chip_select = 1'b0;
  endtask
  task automatic trig;
    @(negedge clk);
    trigger = 1'b1;
    @(negedge clk);
    trigger = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/tppm_tb_top.sv */
// Self-checking testbench for the three-phase pwm modulator
`timescale 1ns/10ps
`default_nettype none
module tppm_tb_top;
  typedef struct packed {
    logic [2:0] dv;
    logic [7:0] v;
    logic [5:0] r;
  } tppm_row_t;
  tppm_row_t rows [8] = '{'{3'h0, 8'h03, 6'h04}, '{3'h1, 8'h02, 6'h06},
    '{3'h2, 8'h02, 6'h08}, '{3'h3, 8'h01, 6'h0c}, '{3'h4, 8'h01, 6'h10},
    '{3'h5, 8'h01, 6'h18}, '{3'h6, 8'h01, 6'h20}, '{3'h7, 8'h01, 6'h30}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic inhibit = 1'b0;
  logic set_status = 1'b0;
  logic clear_status = 1'b0;
  logic chip_reset_in = 1'b0;
  wire logic [7:0] host_bus;
  wire logic addr_latch, write_strobe, chip_select, trigger;
  wire logic crystal_out, status_out;
  wire logic [5:0] o;
  int n_fail = 0;
  int tests_run = 0;
  tppm_host host_u (.clk(clk), .host_bus(host_bus),
    .addr_latch(addr_latch), .write_strobe(write_strobe),
    .chip_select(chip_select), .trigger(trigger));
  tppm_top dut_u (.clk(clk), .resetn(resetn), .clk_en(1'b1),
    .host_bus(host_bus), .addr_latch(addr_latch),
    .write_strobe(write_strobe), .chip_select(chip_select),
    .trigger(trigger), .inhibit(inhibit), .set_status(set_status),
    .clear_status(clear_status), .chip_reset_in(chip_reset_in),
    .crystal_out(crystal_out), .status_out(status_out),
    .phase_one_drive_out(o[5]), .phase_one_complement_out(o[4]),
    .phase_two_drive_out(o[3]), .phase_two_complement_out(o[2]),
    .phase_three_drive_out(o[1]), .phase_three_complement_out(o[0]));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [5:0] e,
    input logic [5:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic pulse(input int lo, input int hi, input logic cmp);
    int w;
    w = 0;
    host_u.trig();
    for (int t = 0; t < 400 && (w == 0 || o[5] === 1'b0); t++) begin
      if (o[5] === 1'b0) w++;
      if (cmp) chk("pair", 6'({~o[5], 1'b1, o[5]}),
        6'({o[4], o[3], o[1]}));
      @(negedge clk);
    end
    chk("width", 6'h01, 6'(w >= lo && w <= hi));
  endtask
  task end_sim;
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #3000000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (5) @(negedge clk);
    chk("reset", 6'h3f, o);
    resetn = 1'b1;
    host_u.wr(3'h1, 8'h00, 1'b1);
    host_u.wr(3'h3, 8'h00, 1'b1);
    foreach (rows[i]) begin
      host_u.wr(3'h4, {5'h00, rows[i].dv}, 1'b1);
      host_u.wr(3'h0, rows[i].v, 1'b1);
      host_u.wr(3'h2, rows[i].v, 1'b1);
      pulse((rows[i].v - 1) * rows[i].r + 1,
        rows[i].v * rows[i].r + 2, 1'b1);
    end
    host_u.wr(3'h2, 8'h00, 1'b1);
    host_u.wr(3'h0, 8'h00, 1'b1);
    host_u.wr(3'h0, 8'h05, 1'b0);
    host_u.wr(3'h5, 8'h07, 1'b1);
    pulse(0, 0, 1'b1);
    host_u.wr(3'h4, 8'h00, 1'b1);
    host_u.wr(3'h3, 8'h03, 1'b1);
    host_u.wr(3'h0, 8'h05, 1'b1);
    pulse(5, 14, 1'b0);
    host_u.wr(3'h4, 8'h01, 1'b1);
    // Off time longer than the dead time before the next pulse
    repeat (24) @(negedge clk);
    pulse(7, 20, 1'b0);
    host_u.wr(3'h3, 8'h00, 1'b1);
    host_u.wr(3'h0, 8'h0a, 1'b1);
    host_u.trig();
    repeat (5) @(negedge clk);
    inhibit = 1'b1;
    repeat (2) @(negedge clk);
    chk("inhibit", 6'h3f, o);
    inhibit = 1'b0;
    set_status = 1'b1;
    @(negedge clk);
    set_status = 1'b0;
    repeat (2) @(negedge clk);
    chk("held", 6'h3f, o);
    chk("status", 6'h01, 6'(status_out));
    clear_status = 1'b1;
    @(negedge clk);
    clear_status = 1'b0;
    repeat (2) @(negedge clk);
    chk("status", 6'h00, 6'(status_out));
    chk("resume", 6'h00, 6'(o[5]));
    chip_reset_in = 1'b1;
    repeat (2) @(negedge clk);
    chk("chip_reset", 6'h3f, o);
    chip_reset_in = 1'b0;
    // Loaded pulse would still run here had the counter not been cleared
    repeat (3) @(negedge clk);
    chk("stopped", 6'h01, 6'(o[5]));
    end_sim();
  end
endmodule
`default_nettype wire
